// >>> common/cbu_pkg.sv
// package of the conditional branch unit: status bit positions, branch codes, reset values
// assumes a status byte laid out with one flag per bit as named below
package cbu_pkg;

    // status register bit positions
    localparam int FLAG_C_POS = 0;
    localparam int FLAG_Z_POS = 1;
    localparam int FLAG_N_POS = 2;
    localparam int FLAG_V_POS = 3;
    localparam int FLAG_S_POS = 4;
    localparam int FLAG_H_POS = 5;
    localparam int FLAG_T_POS = 6;
    localparam int FLAG_I_POS = 7;
    localparam int FLAG_W     = 8;

    // default widths
    localparam int PC_W_DEF  = 16;
    localparam int OFF_W_DEF = 7;

    // reset values
    localparam logic [15:0] PC_RESET_VAL = 16'h0000;
    localparam logic [7:0]  FLAG_RESET_VAL = 8'h00;

    // cycles spent by each branch outcome
    localparam int CYC_NOT_TAKEN = 1;
    localparam int CYC_TAKEN     = 2;

    // decoded instruction classes seen by the unit
    typedef enum logic [3:0] {
        OP_SEQUENTIAL,
        OP_BRANCH_EQUAL,
        OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_SET,
        OP_BRANCH_CARRY_CLEAR,
        OP_BRANCH_SAME_OR_HIGHER,
        OP_BRANCH_LOWER,
        OP_BRANCH_MINUS,
        OP_BRANCH_PLUS,
        OP_BRANCH_SIGNED_GE,
        OP_BRANCH_SIGNED_LT,
        OP_BRANCH_HALF_CARRY_SET,
        OP_BRANCH_HALF_CARRY_CLEAR,
        OP_BRANCH_TRANSFER_SET,
        OP_BRANCH_TRANSFER_CLEAR
    } cbu_op_e;

    typedef enum logic {
        ST_ISSUE,
        ST_REFILL
    } cbu_state_e;

endpackage

// >>> hdl/cbu_cond_eval.sv
// condition evaluator: decides whether a decoded branch is taken
// assumes op and flags are stable in the cycle they are sampled; purely combinational
module cbu_cond_eval (
    input  wire cbu_pkg::cbu_op_e op,
    input  wire logic [cbu_pkg::FLAG_W-1:0] flags,
    output logic                 take
);
    logic c;
    logic z;
    logic n;
    logic v;
    logic h;
    logic t;

    assign c = flags[cbu_pkg::FLAG_C_POS];
    assign z = flags[cbu_pkg::FLAG_Z_POS];
    assign n = flags[cbu_pkg::FLAG_N_POS];
    assign v = flags[cbu_pkg::FLAG_V_POS];
    assign h = flags[cbu_pkg::FLAG_H_POS];
    assign t = flags[cbu_pkg::FLAG_T_POS];

    always_comb begin
        case (op)
            cbu_pkg::OP_BRANCH_EQUAL:            take = z;
            cbu_pkg::OP_BRANCH_NOT_EQUAL:        take = ~z;
            cbu_pkg::OP_BRANCH_CARRY_SET:        take = c;
            cbu_pkg::OP_BRANCH_LOWER:            take = c;
            cbu_pkg::OP_BRANCH_CARRY_CLEAR:      take = ~c;
            cbu_pkg::OP_BRANCH_SAME_OR_HIGHER:   take = ~c;
            cbu_pkg::OP_BRANCH_MINUS:            take = n;
            cbu_pkg::OP_BRANCH_PLUS:             take = ~n;
            cbu_pkg::OP_BRANCH_SIGNED_GE:        take = ~(n ^ v);
            cbu_pkg::OP_BRANCH_SIGNED_LT:        take = n ^ v;
            cbu_pkg::OP_BRANCH_HALF_CARRY_SET:   take = h;
            cbu_pkg::OP_BRANCH_HALF_CARRY_CLEAR: take = ~h;
            cbu_pkg::OP_BRANCH_TRANSFER_SET:     take = t;
            cbu_pkg::OP_BRANCH_TRANSFER_CLEAR:   take = ~t;
            default:                             take = 1'b0;
        endcase
    end

endmodule // cbu_cond_eval

// >>> hdl/cbu_branch_unit.sv
// branch resolution unit: holds the program counter and resolves relative conditional branches
// assumes one decoded instruction offered per cycle with instValid, held until instReady accepts
// What this block does
// - taken branch loads program counter with current value plus signed offset plus one
// - not-equal branch taken only while zero flag is clear
// - carry-set and lower branches taken only while carry flag is one
// - carry-clear and same-or-higher branches taken only while carry flag is zero
// - minus branch taken on negative one, plus branch on negative zero
// - signed greater-or-equal taken when negative xor overflow is zero
// - signed less-than taken when negative xor overflow is one
// - half-carry set and cleared branches follow the half carry flag
// - transfer set and cleared branches follow the user transfer flag
module cbu_branch_unit #(
    parameter int PC_W  = cbu_pkg::PC_W_DEF,
    parameter int OFF_W = cbu_pkg::OFF_W_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       instValid,
    input  wire cbu_pkg::cbu_op_e           instOp,
    input  wire logic [OFF_W-1:0]           branchOffset,
    input  wire logic [cbu_pkg::FLAG_W-1:0] statusIn,
    output logic                            instReady,
    output logic [PC_W-1:0]                 progCounter,
    output logic                            branchTaken,
    output logic [cbu_pkg::FLAG_W-1:0]      statusOut
);

    // offset must keep at least one magnitude bit beside its sign
    if (OFF_W < 2) begin : g_bad_off_w
        $error("cbu_branch_unit: OFF_W below 2");
    end

    // the widest backward jump must still fit the counter range
    if (PC_W <= OFF_W) begin : g_bad_pc_vs_off
        $error("cbu_branch_unit: PC_W must exceed OFF_W");
    end

    // the reset constant holds 16 bits; a wider counter would start partly unknown
    if (PC_W > 16) begin : g_bad_pc_w
        $error("cbu_branch_unit: PC_W above 16");
    end

    // a narrow counter must still hold the reset address without losing bits
    if ((cbu_pkg::PC_RESET_VAL >> PC_W) != 16'h0000) begin : g_bad_pc_reset
        $error("cbu_branch_unit: reset address does not fit PC_W");
    end

    // the issue state finishes every instruction in a single cycle
    if (cbu_pkg::CYC_NOT_TAKEN != 1) begin : g_bad_seq_cycles
        $error("cbu_branch_unit: not-taken cost must be one cycle");
    end

    // the refill state needs at least one cycle to count
    if (cbu_pkg::CYC_TAKEN <= cbu_pkg::CYC_NOT_TAKEN) begin : g_bad_jump_cycles
        $error("cbu_branch_unit: taken cost must exceed not-taken cost");
    end

    localparam logic [PC_W-1:0] PC_STEP   = PC_W'(1);
    localparam int              SIGN_BIT  = OFF_W - 1;

    // refill length follows the package cycle counts; one cycle by default
    localparam int              STALL_CYC = cbu_pkg::CYC_TAKEN - cbu_pkg::CYC_NOT_TAKEN;
    localparam int              STALL_W   = (STALL_CYC > 1) ? $clog2(STALL_CYC) : 1;

    // all state lives in one word; its next value is built in one place below
    typedef struct packed {
        cbu_pkg::cbu_state_e        state;
        logic [PC_W-1:0]            pc;
        logic                       ready;
        logic                       taken;
        logic [STALL_W-1:0]         stall;
        logic [cbu_pkg::FLAG_W-1:0] flags;
    } cbu_regs_s;

    // the value the whole state word takes while sys_rst is high
    localparam cbu_regs_s REGS_RESET = '{
        state: cbu_pkg::ST_ISSUE,
        pc:    cbu_pkg::PC_RESET_VAL[PC_W-1:0],
        ready: 1'b1,
        taken: 1'b0,
        stall: '0,
        flags: cbu_pkg::FLAG_RESET_VAL
    };

    // regs_r is the only clocked state; regs_nxt is its combinational next value
    cbu_regs_s regs_r;
    cbu_regs_s regs_nxt;

    logic            condTrue;
    logic            accept;
    logic            isBranch;
    logic            takeNow;
    logic            stepNow;

    logic [PC_W-1:0] offsetExt;
    logic [PC_W-1:0] pcSeq;
    logic [PC_W-1:0] pcJump;
    logic [PC_W-1:0] pcNext;

    // conditions are decoded apart, so this file only sequences the counter
    cbu_cond_eval u_cond (
        .op    (instOp),
        .flags (statusIn),
        .take  (condTrue)
    );

    // an offer made while the refill cycle runs is not accepted and must be held
    assign accept = instValid & regs_r.ready;

    // sign extension: low bits copy the offset, every higher bit repeats its sign
    for (genvar gi = 0; gi < PC_W; gi++) begin : g_ext
        if (gi < OFF_W) begin : g_low
            assign offsetExt[gi] = branchOffset[gi];
        end else begin : g_high
            assign offsetExt[gi] = branchOffset[SIGN_BIT];
        end
    end

    // only a real branch may redirect; a sequential op always steps by one
    always_comb begin
        case (instOp)
            // zero flag
            cbu_pkg::OP_BRANCH_EQUAL:            isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_NOT_EQUAL:        isBranch = 1'b1;
            // carry flag
            cbu_pkg::OP_BRANCH_CARRY_SET:        isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_CARRY_CLEAR:      isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_SAME_OR_HIGHER:   isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_LOWER:            isBranch = 1'b1;
            // negative flag
            cbu_pkg::OP_BRANCH_MINUS:            isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_PLUS:             isBranch = 1'b1;
            // negative and overflow together
            cbu_pkg::OP_BRANCH_SIGNED_GE:        isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_SIGNED_LT:        isBranch = 1'b1;
            // half carry flag
            cbu_pkg::OP_BRANCH_HALF_CARRY_SET:   isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_HALF_CARRY_CLEAR: isBranch = 1'b1;
            // user transfer bit
            cbu_pkg::OP_BRANCH_TRANSFER_SET:     isBranch = 1'b1;
            cbu_pkg::OP_BRANCH_TRANSFER_CLEAR:   isBranch = 1'b1;
            default:                             isBranch = 1'b0;
        endcase
    end

    // a branch is taken only when it is accepted and its condition holds
    assign takeNow = accept & isBranch & condTrue;
    assign stepNow = accept & ~takeNow;

    // both targets wrap modulo the counter width
    assign pcSeq  = regs_r.pc + PC_STEP;
    assign pcJump = regs_r.pc + offsetExt + PC_STEP;

    // target chosen ahead of the state logic so both adders stay shared
    always_comb begin
        if (takeNow) begin
            pcNext = pcJump;
        end else if (stepNow) begin
            pcNext = pcSeq;
        end else begin
            // idle, or an offer refused during refill: the counter holds
            pcNext = regs_r.pc;
        end
    end

    always_comb begin
        // defaults: hold state, ready and stall, drop the one-cycle taken pulse
        regs_nxt.state = regs_r.state;
        regs_nxt.pc    = pcNext;
        regs_nxt.ready = regs_r.ready;
        regs_nxt.taken = 1'b0;
        regs_nxt.stall = regs_r.stall;
        // flags pass through untouched; this unit never writes a status bit
        regs_nxt.flags = statusIn;

        case (regs_r.state)
            cbu_pkg::ST_ISSUE: begin
                if (takeNow) begin
                    regs_nxt.taken = 1'b1;
                    // the refill state makes a taken branch cost two cycles
                    regs_nxt.state = cbu_pkg::ST_REFILL;
                    regs_nxt.ready = 1'b0;
                    regs_nxt.stall = STALL_W'(STALL_CYC - 1);
                end
            end

            cbu_pkg::ST_REFILL: begin
                // the fetch slot is spent refilling; pc holds and any offer is refused
                if (regs_r.stall == '0) begin
                    regs_nxt.state = cbu_pkg::ST_ISSUE;
                    regs_nxt.ready = 1'b1;
                end else begin
                    // longer refill settings count down here
                    regs_nxt.stall = regs_r.stall - STALL_W'(1);
                end
            end

            default: begin
                regs_nxt.state = cbu_pkg::ST_ISSUE;
                regs_nxt.ready = 1'b1;
            end
        endcase
    end

    // synchronous reset: the whole state word loads its reset value at one edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regs_r <= REGS_RESET;
        end else begin
            regs_r <= regs_nxt;
        end
    end

    // every output is a field of the state register, so none has a combinational path
    assign instReady   = regs_r.ready;
    assign progCounter = regs_r.pc;
    assign branchTaken = regs_r.taken;
    assign statusOut   = regs_r.flags;

endmodule // cbu_branch_unit

// >>> dv/cbu_branch_unit_chk.sv
// checker of the branch unit: timing and condition relations at its ports
// assumes it is bound into every cbu_branch_unit
module cbu_branch_unit_chk #(
    parameter int PC_W  = cbu_pkg::PC_W_DEF,
    parameter int OFF_W = cbu_pkg::OFF_W_DEF
) (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic                       instValid,
    input wire cbu_pkg::cbu_op_e           instOp,
    input wire logic [OFF_W-1:0]           branchOffset,
    input wire logic [cbu_pkg::FLAG_W-1:0] statusIn,
    input wire logic                       instReady,
    input wire logic [PC_W-1:0]            progCounter,
    input wire logic                       branchTaken,
    input wire logic [cbu_pkg::FLAG_W-1:0] statusOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire acc = instValid && instReady;
    wire [7:0] s = statusIn;
    property p_tgt;
        acc ##1 branchTaken |->
            progCounter == $past(progCounter) + PC_W'($signed($past(branchOffset))) + 1'b1;
    endproperty
    a_tgt: assert property (p_tgt) else $error("taken target wrong");
    property p_ntk; acc ##1 !branchTaken |-> progCounter == $past(progCounter) + 1'b1; endproperty
    a_ntk: assert property (p_ntk) else $error("sequential pc wrong");
    property p_rdy; branchTaken |-> !instReady ##1 instReady; endproperty
    a_rdy: assert property (p_rdy) else $error("taken stall not one cycle");
    property p_st; !$past(sys_rst) |-> statusOut == $past(statusIn); endproperty
    a_st: assert property (p_st) else $error("status altered");
    property p_ne; acc && instOp == cbu_pkg::OP_BRANCH_NOT_EQUAL && s[1] |=> !branchTaken;
    endproperty
    a_ne: assert property (p_ne) else $error("not-equal taken on zero");
    property p_cs;
        acc && instOp inside {cbu_pkg::OP_BRANCH_CARRY_SET, cbu_pkg::OP_BRANCH_LOWER} && !s[0]
            |=> !branchTaken;
    endproperty
    a_cs: assert property (p_cs) else $error("carry-set taken on carry clear");
    property p_ge; acc && instOp == cbu_pkg::OP_BRANCH_SIGNED_GE && (s[2] ^ s[3]) |=> !branchTaken;
    endproperty
    a_ge: assert property (p_ge) else $error("signed ge taken wrongly");
    property p_lt; acc && instOp == cbu_pkg::OP_BRANCH_SIGNED_LT && !(s[2] ^ s[3]) |=> !branchTaken;
    endproperty
    a_lt: assert property (p_lt) else $error("signed lt taken wrongly");
endmodule // cbu_branch_unit_chk

bind cbu_branch_unit cbu_branch_unit_chk #(.PC_W(PC_W), .OFF_W(OFF_W)) i_chk (.clk, .sys_rst,
    .instValid, .instOp, .branchOffset, .statusIn, .instReady, .progCounter, .branchTaken,
    .statusOut);

// >>> dv/tb_top.sv
// bench of the branch unit: every op against flag patterns, then a mid-run reset
// assumes the checker is bound; inputs change on the falling edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              instValid = 1'b0;
    cbu_pkg::cbu_op_e  instOp = cbu_pkg::OP_SEQUENTIAL;
    logic [6:0]        branchOffset = 7'h00;
    logic [7:0]        statusIn = 8'h00;
    logic              instReady;
    logic              branchTaken;
    logic [15:0]       progCounter;
    logic [7:0]        statusOut;
    int                bad_count = 0;
    int                samples_checked = 0;
    cbu_branch_unit i_dut (.clk(clk), .sys_rst(sys_rst), .instValid(instValid), .instOp(instOp),
        .branchOffset(branchOffset), .statusIn(statusIn), .instReady(instReady),
        .progCounter(progCounter), .branchTaken(branchTaken), .statusOut(statusOut));
    always #50 clk = ~clk;
    task automatic cmp(logic [15:0] g, logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic take(cbu_pkg::cbu_op_e o, logic [7:0] s);
        case (o)
            cbu_pkg::OP_BRANCH_EQUAL: return s[1];
            cbu_pkg::OP_BRANCH_NOT_EQUAL: return !s[1];
            cbu_pkg::OP_BRANCH_CARRY_SET, cbu_pkg::OP_BRANCH_LOWER: return s[0];
            cbu_pkg::OP_BRANCH_CARRY_CLEAR, cbu_pkg::OP_BRANCH_SAME_OR_HIGHER: return !s[0];
            cbu_pkg::OP_BRANCH_MINUS: return s[2];
            cbu_pkg::OP_BRANCH_PLUS: return !s[2];
            cbu_pkg::OP_BRANCH_SIGNED_GE: return !(s[2] ^ s[3]);
            cbu_pkg::OP_BRANCH_SIGNED_LT: return s[2] ^ s[3];
            cbu_pkg::OP_BRANCH_HALF_CARRY_SET: return s[5];
            cbu_pkg::OP_BRANCH_HALF_CARRY_CLEAR: return !s[5];
            cbu_pkg::OP_BRANCH_TRANSFER_SET: return s[6];
            cbu_pkg::OP_BRANCH_TRANSFER_CLEAR: return !s[6];
            default: return 1'b0;
        endcase
    endfunction
    // valid stays high between calls, so the stale offer during a stall must be ignored
    task automatic issue(cbu_pkg::cbu_op_e o, logic [6:0] k, logic [7:0] s);
        logic        t;
        logic [15:0] e;
        t = take(o, s);
        e = progCounter + 16'h0001 + (t ? {{9{k[6]}}, k} : 16'h0000);
        instValid = 1'b1;
        instOp = o;
        branchOffset = k;
        statusIn = s;
        @(negedge clk);
        cmp(progCounter, e);
        cmp({15'h0000, branchTaken}, {15'h0000, t});
        cmp({15'h0000, instReady}, {15'h0000, !t});
        cmp({8'h00, statusOut}, {8'h00, s});
        if (t) begin
            @(negedge clk);
            cmp(progCounter, e);
        end
    endtask
    task automatic t_table;
        logic [7:0] pat [4] = '{8'h00, 8'hff, 8'h08, 8'h24};
        for (int o = 0; o < 15; o++) begin
            for (int i = 0; i < 4; i++) begin
                issue(cbu_pkg::cbu_op_e'(o), o[0] ? 7'h40 : 7'h3f, pat[i]);
            end
        end
        instValid = 1'b0;
        $display("t_table done");
    endtask
    task automatic t_reset;
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        cmp(progCounter, cbu_pkg::PC_RESET_VAL);
        cmp({14'h0000, instReady, branchTaken}, 16'h0002);
        cmp({8'h00, statusOut}, {8'h00, cbu_pkg::FLAG_RESET_VAL});
        // first offer at the first edge after release, taken from the reset address
        issue(cbu_pkg::OP_BRANCH_NOT_EQUAL, 7'h05, 8'h00);
        instValid = 1'b0;
        $display("t_reset done");
    endtask
    task automatic test_done;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_table;
        t_reset;
        test_done;
    end
    initial begin
        #(400 * 100);
        bad_count++;
        test_done;
    end
endmodule // tb_top
